// >>> encoder_line_model.sv
// Purpose: Far-side lines: encoder count and reset, aux levels
// Assumes: Lines change right after a rising mclk
// Notes: Refclock pin stays low between requested edges
`timescale 1ns/1ps
module encoder_line_model (
  input wire logic mclk,
  output logic refclk_pin,
  output logic [7:0] aux_digital_inputs,
  output logic [1:0] enc_count_pin,
  output logic [1:0] enc_reset_pin
);
  initial begin
    refclk_pin = 1'b0;
    aux_digital_inputs = 8'h00;
    enc_count_pin = 2'h0;
    enc_reset_pin = 2'h0;
  end
  // Both levels held len cycles; callers keep len at 16 or more
  task automatic pulse(input int idx, input int len);
    @(posedge mclk);
    enc_count_pin[idx] <= 1'b1;
    repeat (len) @(posedge mclk);
    enc_count_pin[idx] <= 1'b0;
    repeat (len) @(posedge mclk);
  endtask
  // One reference edge; held high long enough for the synchroniser
  task automatic ref_tick();
    @(posedge mclk);
    refclk_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    refclk_pin <= 1'b0;
  endtask
  task automatic set_lines(input logic [7:0] lvl, input logic [1:0] rst);
    @(posedge mclk);
    aux_digital_inputs <= lvl;
    enc_reset_pin <= rst;
  endtask
endmodule

// >>> stamp_fmt_properties.sv
// Purpose: Port properties of the stamp formatter
// Assumes: Command flags shadowed from observed writes
// Notes: Aux judged only when settled, as it crosses two sync stages
`timescale 1ns/1ps
`include "trigger_timestamp_formatter_params.svh"
module stamp_fmt_properties #(
  parameter int BUF_DEPTH = 2,
  parameter int ENC_W = 10
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic trig_event,
  input wire logic start_reset_timing,
  input wire logic refclk_pin,
  input wire logic [7:0] aux_digital_inputs,
  input wire logic [1:0] enc_count_pin,
  input wire logic [1:0] enc_reset_pin,
  input wire logic stamp_valid,
  input wire logic stamp_ready,
  input wire logic [63:0] stamp_data
);
  logic [31:0] cmd_q;
  logic [55:0] cnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == `TSF_OFS_CMD) begin
      cmd_q <= reg_wdata & 32'h0000_3001;
    end
  end
  // Clears on start-reset or on a command write with the clear bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 56'h0;
    end else if (start_reset_timing
                 || (reg_wr && reg_addr == `TSF_OFS_CMD && reg_wdata[1])) begin
      cnt_q <= 56'h0;
    end else begin
      cnt_q <= cnt_q + 56'h1;
    end
  end
  sequence fresh_trig;
    trig_event && !stamp_valid;
  endsequence
  sequence aux_settled;
    $stable(aux_digital_inputs) [*4];
  endsequence
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle zero");
  cmd_read_a: assert property (reg_rd && reg_addr == `TSF_OFS_CMD
    |=> reg_rdata == ($past(cmd_q) & 32'h0000_3001))
    else $error("command readback wrong");
  valid_rise_a: assert property (fresh_trig |=> stamp_valid)
    else $error("stamp not offered after trigger");
  stall_hold_a: assert property (stamp_valid && !stamp_ready
    |=> stamp_valid && $stable(stamp_data))
    else $error("stamp changed while stalled");
  zero_top_a: assert property (fresh_trig ##0 cmd_q[13:12] == 2'h0
    |=> stamp_data[63:56] == 8'h00)
    else $error("top byte not zero");
  count_a: assert property (fresh_trig ##0 cmd_q[13:0] == 14'h0
    |=> stamp_data[55:0] == $past(cnt_q))
    else $error("captured count wrong");
  aux_top_a: assert property (aux_settled ##0 fresh_trig
    ##0 cmd_q[13:12] == 2'h1
    |=> stamp_data[63:56] == $past(aux_digital_inputs))
    else $error("aux byte wrong");
  enc_clear_a: assert property (fresh_trig ##0 cmd_q[13]
    && enc_reset_pin == 2'h3 |=> stamp_data[63:44] == 20'h0)
    else $error("encoder fields not cleared");
endmodule
bind trigger_timestamp_formatter stamp_fmt_properties #(
  .BUF_DEPTH(BUF_DEPTH),
  .ENC_W(ENC_W)
) u_props (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .trig_event(trig_event),
  .start_reset_timing(start_reset_timing), .refclk_pin(refclk_pin),
  .aux_digital_inputs(aux_digital_inputs), .enc_count_pin(enc_count_pin),
  .enc_reset_pin(enc_reset_pin), .stamp_valid(stamp_valid),
  .stamp_ready(stamp_ready), .stamp_data(stamp_data)
);

// >>> trigger_timestamp_formatter.sv
// Purpose: Build and queue the 64-bit word stored per trigger event
// Assumes: mclk is the sampling clock; trig_event is a one-cycle pulse
// Assumes: Encoder and aux lines are asynchronous pins
// Notes: Two-entry buffer toward the stamp sink; a full buffer not popped
// Notes: in that cycle drops the stamp and raises a sticky overrun flag
//
// Contract
// - Stamp is 56 bits placed in low seven bytes of 64-bit word.
// - Counter counts sampling clocks from zero since last counter reset.
// - Captured value marks internal trigger, fixed lag versus external.
// - Default format zeros the top byte of every stored word.
// - Aux capture puts eight aux input levels in the top byte.
// - Flag 1000h enables aux capture; zero selects zero filling.
// - Encoder format keeps two 10-bit counters, own count and reset.
// - Encoder counter increments on synchronized rising count edge.
// - Encoder reset high clears its counter asynchronously.
// - Encoder reset release is synchronized to the sampling clock.
// - Encoder standard: enc1 63..54, enc2 53..44, 44-bit counter.
// - Flag 2000h captures both encoder counters in upper 20 bits.
// - Format flags are independent bits usable with every mode; the code lets the encoder flag win when both are set.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "trigger_timestamp_formatter_params.svh"

module trigger_timestamp_formatter #(
  parameter int BUF_DEPTH = `TSF_BUF_DEPTH,
  parameter int ENC_W = `TSF_ENC_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`TSF_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic trig_event,
  input wire logic start_reset_timing,
  input wire logic refclk_pin,
  input wire logic [`TSF_AUX_W-1:0] aux_digital_inputs,
  input wire logic [`TSF_ENC_N-1:0] enc_count_pin,
  input wire logic [`TSF_ENC_N-1:0] enc_reset_pin,
  output logic stamp_valid,
  input wire logic stamp_ready,
  output logic [`TSF_STAMP_W-1:0] stamp_data
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);

  logic [31:0] cmd_q;
  logic [31:0] rdata_q;
  logic overrun_q;
  logic [`TSF_TS_W-1:0] ts_cnt_q;
  logic [`TSF_SEC_W-1:0] sec_cnt_q;
  logic [`TSF_SAMP_W-1:0] samp_cnt_q;
  logic [`TSF_SYNC_STAGES-1:0] ref_sync_q;
  logic ref_prev_q;
  logic ref_edge;
  logic [`TSF_AUX_W-1:0] aux_meta_q;
  logic [`TSF_AUX_W-1:0] aux_q;
  logic [ENC_W-1:0] enc_val [`TSF_ENC_N];
  logic cnt_clear;
  logic refclk_mode;
  trigger_timestamp_formatter_pkg::upper_fmt_e fmt;
  trigger_timestamp_formatter_pkg::stamp_t stamp_word;
  trigger_timestamp_formatter_pkg::stamp_t buf_mem_q [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] fill_q;
  logic buf_full;
  logic buf_push;
  logic buf_pop;
  logic cmd_wr;

  assign cmd_wr = reg_wr && (reg_addr == `TSF_OFS_CMD);

  // Command word; clear bit is a strobe and never stored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= `TSF_CMD_RESET;
    end else if (cmd_wr) begin
      cmd_q <= reg_wdata & `TSF_CMD_WMASK
               & ~(32'h0000_0001 << `TSF_BIT_CNT_CLR);
    end
  end

  assign refclk_mode = cmd_q[`TSF_BIT_REFCLK];
  assign cnt_clear = start_reset_timing
                     || (cmd_wr && reg_wdata[`TSF_BIT_CNT_CLR]);

  // Format select; encoder wins when both flags are set
  always_comb begin
    if (cmd_q[`TSF_BIT_ENC]) begin
      fmt = trigger_timestamp_formatter_pkg::FMT_ENC;
    end else if (cmd_q[`TSF_BIT_AUX]) begin
      fmt = trigger_timestamp_formatter_pkg::FMT_AUX;
    end else begin
      fmt = trigger_timestamp_formatter_pkg::FMT_PLAIN;
    end
  end

  // Sample clock counter, free running since last clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ts_cnt_q <= '0;
    end else if (cnt_clear) begin
      ts_cnt_q <= '0;
    end else begin
      ts_cnt_q <= ts_cnt_q + 1'b1;
    end
  end

  // Reference clock pin, two stages before edge detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref_sync_q <= '0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_sync_q <= {ref_sync_q[`TSF_SYNC_STAGES-2:0], refclk_pin};
      ref_prev_q <= ref_sync_q[`TSF_SYNC_STAGES-1];
    end
  end

  assign ref_edge = ref_sync_q[`TSF_SYNC_STAGES-1] && !ref_prev_q;

  // Seconds and in-second sample counters for refclock mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sec_cnt_q <= '0;
      samp_cnt_q <= '0;
    end else if (cnt_clear) begin
      sec_cnt_q <= '0;
      samp_cnt_q <= '0;
    end else if (ref_edge) begin
      sec_cnt_q <= sec_cnt_q + 1'b1;
      samp_cnt_q <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_q + 1'b1;
    end
  end

  // Static aux levels; synchronized so a changing pin cannot go metastable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aux_meta_q <= '0;
      aux_q <= '0;
    end else begin
      aux_meta_q <= aux_digital_inputs;
      aux_q <= aux_meta_q;
    end
  end

  // Encoder channels
  for (genvar i = 0; i < `TSF_ENC_N; i++) begin : g_enc
    logic clr_n;
    logic [1:0] rst_sync_q;
    logic [`TSF_SYNC_STAGES-1:0] cnt_sync_q;
    logic cnt_prev_q;
    logic [ENC_W-1:0] val_q;

    assign clr_n = resetn && !enc_reset_pin[i];

    // Assert at once, release after two sampling clock edges
    always_ff @(posedge mclk or negedge clr_n) begin
      if (!clr_n) begin
        rst_sync_q <= 2'b00;
      end else begin
        rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
    end

    // Count pin sync; pulses under 16 clocks may be missed
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        cnt_sync_q <= '0;
        cnt_prev_q <= 1'b0;
      end else begin
        cnt_sync_q <= {cnt_sync_q[`TSF_SYNC_STAGES-2:0], enc_count_pin[i]};
        cnt_prev_q <= cnt_sync_q[`TSF_SYNC_STAGES-1];
      end
    end

    // Wraps 1023 to 0
    always_ff @(posedge mclk or negedge rst_sync_q[1]) begin
      if (!rst_sync_q[1]) begin
        val_q <= '0;
      end else if (cnt_sync_q[`TSF_SYNC_STAGES-1] && !cnt_prev_q) begin
        val_q <= val_q + 1'b1;
      end
    end

    assign enc_val[i] = val_q;
  end

  // Word assembly from the counters as they stand at the trigger
  always_comb begin
    stamp_word = '0;
    case (fmt)
      trigger_timestamp_formatter_pkg::FMT_ENC: begin
        if (refclk_mode) begin
          stamp_word = {enc_val[0], enc_val[1],
                        sec_cnt_q[`TSF_ENC_SEC_W-1:0],
                        samp_cnt_q[`TSF_ENC_SAMP_W-1:0]};
        end else begin
          stamp_word = {enc_val[0], enc_val[1],
                        ts_cnt_q[`TSF_ENC_TS_W-1:0]};
        end
      end
      trigger_timestamp_formatter_pkg::FMT_AUX: begin
        if (refclk_mode) begin
          stamp_word = {aux_q, sec_cnt_q, samp_cnt_q};
        end else begin
          stamp_word = {aux_q, ts_cnt_q};
        end
      end
      trigger_timestamp_formatter_pkg::FMT_PLAIN: begin
        if (refclk_mode) begin
          stamp_word = {{`TSF_AUX_W{1'b0}}, sec_cnt_q,
                        samp_cnt_q};
        end else begin
          stamp_word = {{`TSF_AUX_W{1'b0}}, ts_cnt_q};
        end
      end
      default: begin
        stamp_word = {{`TSF_AUX_W{1'b0}}, ts_cnt_q};
      end
    endcase
  end

  // Two-entry buffer toward the sink
  assign buf_full = (fill_q == CNT_W'(BUF_DEPTH));
  assign buf_pop = stamp_valid && stamp_ready;
  // Pop frees a slot in the same cycle, so full-and-draining still takes
  assign buf_push = trig_event && (!buf_full || buf_pop);
  assign stamp_valid = (fill_q != '0);
  assign stamp_data = buf_mem_q[rd_ptr_q];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < BUF_DEPTH; k++) begin
        buf_mem_q[k] <= '0;
      end
    end else if (buf_push) begin
      buf_mem_q[wr_ptr_q] <= stamp_word;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
    end else if (buf_push) begin
      wr_ptr_q <= (wr_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0
                  : wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr_q <= '0;
    end else if (buf_pop) begin
      rd_ptr_q <= (rd_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0
                  : rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fill_q <= '0;
    end else if (buf_push && !buf_pop) begin
      fill_q <= fill_q + 1'b1;
    end else if (buf_pop && !buf_push) begin
      fill_q <= fill_q - 1'b1;
    end
  end

  // Sticky overrun; a new loss wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      overrun_q <= 1'b0;
    end else if (trig_event && !buf_push) begin
      overrun_q <= 1'b1;
    end else if (reg_wr && reg_addr == `TSF_OFS_STATUS && reg_wdata[0]) begin
      overrun_q <= 1'b0;
    end
  end

  // Read data for exactly one cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `TSF_OFS_CMD: rdata_q <= cmd_q;
        `TSF_OFS_ENC: begin
          rdata_q <= {{(32 - 2 * ENC_W){1'b0}}, enc_val[1], enc_val[0]};
        end
        `TSF_OFS_CNT_LO: rdata_q <= ts_cnt_q[31:0];
        `TSF_OFS_CNT_HI: begin
          rdata_q <= {{(64 - `TSF_TS_W){1'b0}}, ts_cnt_q[`TSF_TS_W-1:32]};
        end
        `TSF_OFS_STATUS: begin
          rdata_q <= {{(32 - CNT_W - 1){1'b0}}, fill_q, overrun_q};
        end
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// >>> trigger_timestamp_formatter_params.svh
// Purpose: Offsets, field positions and widths of the stamp formatter
// Assumes: Byte addresses on the register port
// Notes: Included by bare name
`ifndef TRIGGER_TIMESTAMP_FORMATTER_PARAMS_SVH
`define TRIGGER_TIMESTAMP_FORMATTER_PARAMS_SVH

`define TSF_ADDR_W 16
`define TSF_OFS_CMD 16'hb7fc
`define TSF_OFS_ENC 16'hb800
`define TSF_OFS_CNT_LO 16'hb804
`define TSF_OFS_CNT_HI 16'hb808
`define TSF_OFS_STATUS 16'hb80c

`define TSF_CMD_RESET 32'h0000_0000
`define TSF_CMD_WMASK 32'h0000_3003
`define TSF_BIT_REFCLK 0
`define TSF_BIT_CNT_CLR 1
`define TSF_BIT_AUX 12
`define TSF_BIT_ENC 13

`define TSF_STAMP_W 64
`define TSF_TS_W 56
`define TSF_AUX_W 8
`define TSF_ENC_W 10
`define TSF_ENC_N 2
`define TSF_SEC_W 24
`define TSF_SAMP_W 32
`define TSF_ENC_TS_W 44
`define TSF_ENC_SEC_W 14
`define TSF_ENC_SAMP_W 30
`define TSF_SYNC_STAGES 2
`define TSF_MIN_PULSE_CYC 16
`define TSF_BUF_DEPTH 2

`endif

// >>> trigger_timestamp_formatter_pkg.sv
// Purpose: Types shared by the stamp formatter
// Assumes: Constants come from the params header
// Notes: No imports; use package scope
package trigger_timestamp_formatter_pkg;

  typedef enum logic [2:0] {
    FMT_PLAIN = 3'b001,
    FMT_AUX = 3'b010,
    FMT_ENC = 3'b100
  } upper_fmt_e;

  typedef logic [63:0] stamp_t;

endpackage

// >>> trigger_timestamp_formatter_tb.sv
// Purpose: Self-checking bench for the stamp formatter
// Assumes: Far-side lines come from encoder_line_model
// Notes: Full encoder wrap costs about 33k cycles
`timescale 1ns/1ps
`include "trigger_timestamp_formatter_params.svh"
module trigger_timestamp_formatter_tb;
  logic mclk, resetn, reg_wr, reg_rd, trig_event, start_reset_timing;
  logic stamp_valid, stamp_ready, refclk_pin, clr, tick;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v, flags, samp, cp;
  logic [7:0] aux_digital_inputs, aux_v;
  logic [1:0] enc_count_pin, enc_reset_pin;
  logic [63:0] stamp_data, got, msk;
  logic [55:0] cnt, cap, rc;
  logic [55:0] cq [2];
  logic [23:0] sec, cs;
  logic [2:0] ref_d;
  logic [9:0] e1, e2;
  int err_total, comparisons, seed;
  trigger_timestamp_formatter #(.BUF_DEPTH(2), .ENC_W(10)) u_dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_event(trig_event),
    .start_reset_timing(start_reset_timing), .refclk_pin(refclk_pin),
    .aux_digital_inputs(aux_digital_inputs),
    .enc_count_pin(enc_count_pin), .enc_reset_pin(enc_reset_pin),
    .stamp_valid(stamp_valid), .stamp_ready(stamp_ready),
    .stamp_data(stamp_data)
  );
  encoder_line_model u_line (
    .mclk(mclk), .refclk_pin(refclk_pin),
    .aux_digital_inputs(aux_digital_inputs),
    .enc_count_pin(enc_count_pin), .enc_reset_pin(enc_reset_pin)
  );
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Clear from start-reset or command bit 1; ref edge counted 3 edges late
  assign clr = start_reset_timing
               || (reg_wr && reg_addr == `TSF_OFS_CMD && reg_wdata[1]);
  assign tick = ref_d[1] && !ref_d[2];
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {cnt, sec, samp, ref_d} <= '0;
    end else begin
      ref_d <= {ref_d[1:0], refclk_pin};
      cnt <= clr ? 56'h0 : cnt + 56'h1;
      sec <= clr ? 24'h0 : sec + 24'(tick);
      samp <= (clr || tick) ? 32'h0 : samp + 32'h1;
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d compares=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    rc = cnt;
    reg_rd <= 1'b0;
    @(posedge mclk);
    rd_v = reg_rdata;
  endtask
  task automatic fire();
    @(posedge mclk);
    trig_event <= 1'b1;
    @(posedge mclk);
    cap = cnt;
    cs = sec;
    cp = samp;
    trig_event <= 1'b0;
  endtask
  task automatic take(output logic [63:0] w);
    int n;
    n = 0;
    @(posedge mclk);
    while (stamp_valid !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check(64'(stamp_valid), 64'h1);
    stamp_ready <= 1'b1;
    @(posedge mclk);
    w = stamp_data;
    stamp_ready <= 1'b0;
  endtask
  // Encoder flag outranks aux flag; bit 0 selects the split counter
  function automatic logic [63:0] expect_word(input logic [31:0] f,
      input logic [7:0] a, input logic [55:0] c);
    logic [55:0] t;
    t = f[0] ? {cs, cp} : c;
    if (f[13]) begin
      return f[0] ? {e1, e2, cs[13:0], cp[29:0]} : {e1, e2, c[43:0]};
    end
    return f[12] ? {a, t} : {8'h00, t};
  endfunction
  initial begin
    #3_000_000;
    err_total++;
    give_verdict();
  end
  initial begin
    seed = 89;
    {resetn, reg_wr, reg_rd, trig_event, start_reset_timing} = 5'h0;
    {stamp_ready, reg_addr, reg_wdata, e1, e2} = '0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rd(`TSF_OFS_CMD);
    check(64'(rd_v), 64'h0);
    rd(16'h0040);
    check(64'(rd_v), 64'h0);
    for (int i = 0; i < 24; i++) begin
      flags = {18'h0, 2'(i), 10'h0, 1'($random(seed)), 1'($random(seed))};
      aux_v = 8'($random(seed));
      u_line.set_lines(aux_v, 2'h0);
      if (i % 4 == 2) begin
        u_line.ref_tick();
      end
      if (i % 3 == 1) begin
        u_line.pulse(i % 2, 16 + i);
        e1 += 10'(i % 2 == 0);
        e2 += 10'(i % 2);
      end
      start_reset_timing <= (i == 7);
      wr(`TSF_OFS_CMD, flags);
      rd(`TSF_OFS_CMD);
      check(64'(rd_v), 64'(flags & 32'hffff_fffd));
      repeat (4) @(posedge mclk);
      fire();
      take(got);
      msk = expect_word(flags, aux_v, cap);
      check(got, msk);
    end
    for (int k = 0; k < 1024; k++) begin
      u_line.pulse(0, 16);
      e1++;
      if (e1 == 10'h3ff || e1 == 10'h0) begin
        rd(`TSF_OFS_ENC);
        check(64'(rd_v), 64'({e2, e1}));
      end
    end
    u_line.set_lines(aux_v, 2'h3);
    {e1, e2} = 20'h0;
    wr(`TSF_OFS_CMD, 32'h0000_2000);
    fire();
    take(got);
    check(got >> 44, 64'h0);
    u_line.set_lines(aux_v, 2'h0);
    u_line.pulse(1, 16);
    e2++;
    rd(`TSF_OFS_ENC);
    check(64'(rd_v), 64'({e2, e1}));
    // Sink stalls across three back-to-back triggers; third is dropped
    wr(`TSF_OFS_CMD, 32'h0);
    @(posedge mclk);
    trig_event <= 1'b1;
    @(posedge mclk);
    cq[0] = cnt;
    @(posedge mclk);
    cq[1] = cnt;
    @(posedge mclk);
    trig_event <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      take(got);
      check(got, {8'h00, cq[k]});
    end
    @(posedge mclk);
    check(64'(stamp_valid), 64'h0);
    rd(`TSF_OFS_STATUS);
    check(64'(rd_v), 64'h1);
    wr(`TSF_OFS_STATUS, 32'h0000_0001);
    rd(`TSF_OFS_STATUS);
    check(64'(rd_v), 64'h0);
    rd(`TSF_OFS_CNT_LO);
    check(64'(rd_v), 64'(rc[31:0]));
    rd(`TSF_OFS_CNT_HI);
    check(64'(rd_v), 64'(rc[55:32]));
    give_verdict();
  end
endmodule
